// *** hdl/lvpu_top.sv ***
// Leveled vectored interrupt unit: sources, levels, grant and vector fetch
`timescale 1ns/1ps
`default_nettype none
module lvpu_top (
	// Clock, reset, enable
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	// Register port
	input  wire logic [3:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// Interrupt sources
	input  wire logic [10:0] i_src_evt,
	input  wire logic [11:0] i_ext_pin,
	// Processor core
	input  wire logic        i_glb_on,
	input  wire logic        i_glb_off,
	input  wire logic        i_int_ack,
	output logic             o_int_req,
	output logic      [7:0]  o_vector,
	output logic             o_stack_push,
	output logic             o_rom_rd,
	output logic      [15:0] o_rom_addr,
	input  wire logic [7:0]  i_rom_data,
	output logic             o_isr_valid,
	output logic      [15:0] o_isr_addr,
	// Summary interrupt
	output logic             o_irq
);
	logic [7:0]  level_mask_register;
	logic [7:0]  level_priority_register;
	logic [7:0]  lvl_req;
	logic [7:0]  lvl_req_q;
	logic        glb_en;
	logic [22:0] pend;
	logic [22:0] set;
	logic [22:0] sw_clr;
	logic [22:0] hw_clr;
	logic [11:0] edge_sel;
	logic [11:0] pin_s;
	logic [11:0] pin_q;
	logic [11:0] pin_hit;
	logic [7:0]  stat;
	logic [7:0]  stat_en;
	logic [4:0]  win_src;
	logic        grant;
	logic [7:0]  isr_hi;
	lvpu_pkg::lvpu_state_e state;
	lvpu_pkg::lvpu_state_e next_state;
	lvpu_arb_if arb_c ();

	lvpu_sync #(.W(lvpu_pkg::NEXT)) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_pin     (i_ext_pin),
		.o_sync    (pin_s)
	);

	lvpu_arb u_arb (
		.a(arb_c.arb)
	);

	// Pin edges: select bit high takes rising, low takes falling
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pin_q <= 12'h000;
		end else if (i_ce) begin
			pin_q <= pin_s;
		end
	end
	assign pin_hit = (edge_sel & pin_s & ~pin_q)
		| (~edge_sel & ~pin_s & pin_q); // [R11]
	assign set = {pin_hit, i_src_evt}; // [R07]

	// Writes of ones clear pending flags
	always_comb begin
		sw_clr = 23'h000000;
		if (i_reg_wr) begin
			case (i_reg_addr)
				lvpu_pkg::A_PEND0: sw_clr[7:0]   = i_reg_wdata;
				lvpu_pkg::A_PEND1: sw_clr[15:8]  = i_reg_wdata;
				lvpu_pkg::A_PEND2: sw_clr[22:16] = i_reg_wdata[6:0];
				default:           sw_clr        = 23'h000000;
			endcase
		end
	end

	// Hardware clears only self-clearing sources as service begins
	always_comb begin
		hw_clr = 23'h000000;
		if (grant) begin
			hw_clr[win_src] = lvpu_pkg::AUTO_CLR[win_src]; // [R10]
		end
	end

	// A new event wins over a clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pend <= 23'h000000;
		end else if (i_ce) begin
			pend <= (pend & ~(sw_clr | hw_clr)) | set; // [R10]
		end
	end

	// Level request bit is the OR of its sources' flags
	for (genvar l = 0; l < lvpu_pkg::NLVL; l++) begin : g_lvl
		assign lvl_req[l] = |(pend & lvpu_pkg::LVL_SRC[l]); // [R16] [R17]
	end

	// Resolution is purely combinational, fresh every cycle
	assign arb_c.req  = lvl_req & level_mask_register; // [R14] [R18]
	assign arb_c.prio = level_priority_register;

	// Lowest index in the level is its lowest vector
	always_comb begin
		win_src = 5'h00;
		for (int s = lvpu_pkg::NSRC - 1; s >= 0; s--) begin
			if (pend[s] && lvpu_pkg::LVL_SRC[arb_c.level][s]) begin
				win_src = 5'(s); // [R04] [R05]
			end
		end
	end

	assign o_int_req = arb_c.found && glb_en
		&& state == lvpu_pkg::ST_IDLE; // [R01] [R13]
	assign grant = o_int_req && i_int_ack && i_ce;

	// Software registers
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			level_mask_register     <= lvpu_pkg::RST_MASK;
			level_priority_register <= lvpu_pkg::RST_PRIO;
			edge_sel                <= lvpu_pkg::RST_EDGE;
			stat_en                 <= 8'h00;
		end else if (i_ce && i_reg_wr) begin
			case (i_reg_addr)
				lvpu_pkg::A_MASK: level_mask_register     <= i_reg_wdata;
				lvpu_pkg::A_PRIO: level_priority_register <= i_reg_wdata;
				lvpu_pkg::A_EDGE0: edge_sel[7:0]           <= i_reg_wdata;
				lvpu_pkg::A_EDGE1: edge_sel[11:8]          <= i_reg_wdata[3:0];
				lvpu_pkg::A_SEN:  stat_en                 <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// Global enable: off after reset, grant turns it off
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			glb_en <= 1'b0;
		end else if (i_ce) begin
			if (grant || i_glb_off) begin
				glb_en <= 1'b0; // [R08] [R13]
			end else if (i_glb_on) begin
				glb_en <= 1'b1; // [R13]
			end else if (i_reg_wr && i_reg_addr == lvpu_pkg::A_SYS) begin
				glb_en <= i_reg_wdata[lvpu_pkg::SYS_GIE]; // [R13]
			end
		end
	end

	// Status: a level that starts requesting sets its sticky bit
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			lvl_req_q <= 8'h00;
			stat      <= 8'h00;
		end else if (i_ce) begin
			lvl_req_q <= lvl_req;
			if (i_reg_wr && i_reg_addr == lvpu_pkg::A_SCLR) begin
				stat <= (stat & ~i_reg_wdata) | (lvl_req & ~lvl_req_q);
			end else begin
				stat <= stat | (lvl_req & ~lvl_req_q);
			end
		end
	end
	assign o_irq = |(stat & stat_en);

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_ce) begin
			o_reg_rdata <= 8'h00;
			if (i_reg_rd) begin
				case (i_reg_addr)
					lvpu_pkg::A_MASK:  o_reg_rdata <= level_mask_register;
					lvpu_pkg::A_PRIO:  o_reg_rdata <= level_priority_register;
					lvpu_pkg::A_LREQ:  o_reg_rdata <= lvl_req; // [R16]
					lvpu_pkg::A_SYS:   o_reg_rdata <= {7'h00, glb_en};
					lvpu_pkg::A_PEND0: o_reg_rdata <= pend[7:0];
					lvpu_pkg::A_PEND1: o_reg_rdata <= pend[15:8];
					lvpu_pkg::A_PEND2: o_reg_rdata <= {1'b0, pend[22:16]};
					lvpu_pkg::A_EDGE0: o_reg_rdata <= edge_sel[7:0];
					lvpu_pkg::A_EDGE1: o_reg_rdata <= {4'h0, edge_sel[11:8]};
					lvpu_pkg::A_STAT:  o_reg_rdata <= stat;
					lvpu_pkg::A_SEN:   o_reg_rdata <= stat_en;
					default:           o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Service entry: push, fetch high byte, fetch low byte, jump
	always_comb begin
		case (state)
			lvpu_pkg::ST_IDLE: next_state = grant ? lvpu_pkg::ST_PUSH
				: lvpu_pkg::ST_IDLE;
			lvpu_pkg::ST_PUSH: next_state = lvpu_pkg::ST_FHI;
			lvpu_pkg::ST_FHI:  next_state = lvpu_pkg::ST_FLO;
			lvpu_pkg::ST_FLO:  next_state = lvpu_pkg::ST_JUMP;
			lvpu_pkg::ST_JUMP: next_state = lvpu_pkg::ST_IDLE;
			default:           next_state = lvpu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= lvpu_pkg::ST_IDLE;
		end else if (i_ce) begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_vector <= 8'h00;
		end else if (grant) begin
			o_vector <= lvpu_pkg::SRC_VEC[win_src]; // [R04] [R12]
		end
	end

	// Vector bytes: first is the high half of the entry address
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_stack_push <= 1'b0;
			o_rom_rd     <= 1'b0;
			o_rom_addr   <= 16'h0000;
			isr_hi       <= 8'h00;
			o_isr_valid  <= 1'b0;
			o_isr_addr   <= 16'h0000;
		end else if (i_ce) begin
			o_stack_push <= grant; // [R08]
			o_rom_rd     <= 1'b0;
			o_isr_valid  <= 1'b0;
			case (state)
				lvpu_pkg::ST_PUSH: begin
					o_rom_rd   <= 1'b1;
					o_rom_addr <= {lvpu_pkg::ROM_PAGE, o_vector}; // [R09]
				end
				lvpu_pkg::ST_FHI: begin
					o_rom_rd   <= 1'b1;
					o_rom_addr <= {lvpu_pkg::ROM_PAGE, o_vector + 8'h01};
				end
				lvpu_pkg::ST_FLO: begin
					isr_hi <= i_rom_data;
				end
				lvpu_pkg::ST_JUMP: begin
					o_isr_valid <= 1'b1;
					o_isr_addr  <= {isr_hi, i_rom_data}; // [R09]
				end
				default: ;
			endcase
		end
	end

	default clocking cb @(posedge i_core_clk iff i_ce);
	endclocking
	default disable iff (i_rst);

	sequence s_fetch;
		o_rom_rd && o_rom_addr[7:0] == o_vector ##1
		o_rom_rd && o_rom_addr[7:0] == o_vector + 8'h01;
	endsequence

	grant_disable_a: assert property ( // [R08]
		grant |=> !glb_en && o_stack_push && !o_int_req)
		else $error("grant did not disable and push");
	fetch_order_a: assert property ( // [R09]
		grant |=> !o_rom_rd ##1 s_fetch ##2 o_isr_valid)
		else $error("vector fetch out of order");
	isr_build_a: assert property ( // [R09]
		o_isr_valid |-> o_isr_addr
			== {$past(i_rom_data, 2), $past(i_rom_data, 1)})
		else $error("service address not built from vector bytes");
	mask_block_a: assert property ( // [R14]
		grant |-> level_mask_register[arb_c.level]
			&& lvpu_pkg::LVL_SRC[arb_c.level][win_src])
		else $error("masked or foreign level granted");
	e0_first_a: assert property ( // [R05]
		grant && pend[0] && pend[1] && arb_c.level == 3'h0
			|=> o_vector == lvpu_pkg::VEC_E0)
		else $error("E2 served before E0");
	single_vec_a: assert property ( // [R12]
		grant && arb_c.level == 3'h4 |=> o_vector == lvpu_pkg::VEC_D6)
		else $error("wrong vector on single-source level");
	hw_clear_a: assert property ( // [R10]
		grant && lvpu_pkg::AUTO_CLR[win_src] && !set[win_src]
			|=> !pend[$past(win_src)])
		else $error("self-clearing flag left set");
	sw_keep_a: assert property ( // [R10]
		grant && !lvpu_pkg::AUTO_CLR[win_src] && !sw_clr[win_src]
			|=> pend[$past(win_src)])
		else $error("software-cleared flag cleared by grant");
	group_order_a: assert property ( // [R03]
		arb_c.req[0] && arb_c.req[7]
			&& level_priority_register == 8'h00 |-> arb_c.level == 3'h0)
		else $error("default group order broken");
	gie_gate_a: assert property ( // [R13]
		!glb_en && !i_glb_on
			&& !(i_reg_wr && i_reg_addr == lvpu_pkg::A_SYS)
			|-> !o_int_req ##1 !o_int_req)
		else $error("request raised while globally disabled");
	pin_edge_a: assert property ( // [R11]
		edge_sel[0] && pin_s[0] && !pin_q[0] |=> pend[11])
		else $error("rising edge on pin 0 not latched");
endmodule
`default_nettype wire

// *** hdl/lvpu_pkg.sv ***
// Constants and types of the leveled vectored interrupt unit
// Overview of operation
// [R01] Eight request levels, numbered 0 to 7
// [R02] Level number is identity, not priority
// [R03] Priority register orders contending levels
// [R04] Inside a level, lowest vector wins
// [R05] Level 0: vector E0 beats E2
// [R06] Level holds up to 128 vectors
// [R07] 23 sources, each with its own vector
// [R08] Grant disables interrupts, pushes PC, flags
// [R09] Service address from two vector bytes
// [R10] Pending cleared by hardware or by software
// [R11] Pin interrupts on selectable rising/falling edge
// [R12] Single and multi vector level types
// [R13] Mode register bit 0 enables globally
// [R14] Mask register blocks each level
// [R15] Groups A 0-1, B 2-4, C 5-7
// [R16] Level request register shows pending levels
// [R17] Level bit drops when sources clear
// [R18] Priority resolved again every clock
package lvpu_pkg;
	localparam int NLVL = 8;
	localparam int NSRC = 23;
	localparam int NINT = 11;
	localparam int NEXT = 12;
	// Register offsets
	localparam logic [3:0] A_MASK  = 4'h0;
	localparam logic [3:0] A_PRIO  = 4'h1;
	localparam logic [3:0] A_LREQ  = 4'h2;
	localparam logic [3:0] A_SYS   = 4'h3;
	localparam logic [3:0] A_PEND0 = 4'h4;
	localparam logic [3:0] A_PEND1 = 4'h5;
	localparam logic [3:0] A_PEND2 = 4'h6;
	localparam logic [3:0] A_EDGE0 = 4'h7;
	localparam logic [3:0] A_EDGE1 = 4'h8;
	localparam logic [3:0] A_STAT  = 4'h9;
	localparam logic [3:0] A_SCLR  = 4'hA;
	localparam logic [3:0] A_SEN   = 4'hB;
	// Reset values and fields
	localparam logic [7:0]  RST_MASK = 8'h00;
	localparam logic [7:0]  RST_PRIO = 8'h00;
	localparam logic [11:0] RST_EDGE = 12'h000;
	localparam int          SYS_GIE  = 0;
	localparam int          PRIO_GRP = 0;
	localparam int          PRIO_A   = 3;
	localparam int          PRIO_B   = 4;
	localparam int          PRIO_B34 = 5;
	localparam int          PRIO_C   = 6;
	localparam int          PRIO_C67 = 7;
	// Group order encodings of the priority register
	localparam logic [2:0] G_ABC = 3'h0;
	localparam logic [2:0] G_ACB = 3'h1;
	localparam logic [2:0] G_BAC = 3'h2;
	localparam logic [2:0] G_BCA = 3'h3;
	localparam logic [2:0] G_CAB = 3'h4;
	localparam logic [2:0] G_CBA = 3'h5;
	// Vector of each source; source 0 is E0, source 1 is E2
	localparam logic [NSRC-1:0][7:0] SRC_VEC = {
		8'hCE, 8'hCC, 8'hCA, 8'hC8, 8'hC6, 8'hC4, 8'hC2, 8'hC0,
		8'hDE, 8'hDC, 8'hDA, 8'hD8, 8'hD6, 8'hD4, 8'hD2, 8'hD0,
		8'hEC, 8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2, 8'hE0};
	// Sources of each level, ascending index is ascending vector
	localparam logic [NLVL-1:0][NSRC-1:0] LVL_SRC = { // [R06]
		23'h780000, 23'h078000, 23'h007800, 23'h000400,
		23'h000380, 23'h000070, 23'h00000C, 23'h000003};
	// Sources whose pending flag hardware clears on grant
	localparam logic [NSRC-1:0] AUTO_CLR = 23'h000042;
	localparam logic [7:0]      ROM_PAGE = 8'h00;
	localparam logic [7:0]      VEC_E0   = 8'hE0;
	localparam logic [7:0]      VEC_D6   = 8'hD6;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PUSH = 3'h1,
		ST_FHI  = 3'h3,
		ST_FLO  = 3'h2,
		ST_JUMP = 3'h6
	} lvpu_state_e;
endpackage

// *** hdl/lvpu_arb_if.sv ***
// Carrier between the unit and its level resolver
`timescale 1ns/1ps
`default_nettype none
interface lvpu_arb_if;
	logic [7:0] req;
	logic [7:0] prio;
	logic       found;
	logic [2:0] level;
	modport arb  (input req, input prio, output found, output level);
	modport host (output req, output prio, input found, input level);
endinterface
`default_nettype wire

// *** hdl/lvpu_sync.sv ***
// Two-stage synchroniser for external pins
`timescale 1ns/1ps
`default_nettype none
module lvpu_sync #(
	parameter int W = 12
) (
	// Clock and control
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	// Pins and result
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_sync
);
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic meta;
		always_ff @(posedge i_core_clk) begin
			if (i_rst) begin
				meta      <= 1'b0;
				o_sync[b] <= 1'b0;
			end else if (i_ce) begin
				meta      <= i_pin[b];
				o_sync[b] <= meta;
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/lvpu_arb.sv ***
// Level resolver: group and subgroup priority
`timescale 1ns/1ps
`default_nettype none
module lvpu_arb (
	// Masked requests, priority setting and winner
	lvpu_arb_if.arb a
);
	logic       va, vb, vc;
	logic [2:0] wa, wb, wc;
	logic       v34, v67;
	logic [2:0] w34, w67;

	// Group A is levels 0-1, B is 2-4, C is 5-7 [R15]
	always_comb begin
		va  = |a.req[1:0];
		wa  = (a.prio[lvpu_pkg::PRIO_A] ? a.req[1] : !a.req[0])
			? 3'h1 : 3'h0;
		v34 = |a.req[4:3];
		w34 = (a.prio[lvpu_pkg::PRIO_B34] ? a.req[4] : !a.req[3])
			? 3'h4 : 3'h3;
		vb  = a.req[2] | v34;
		wb  = (a.prio[lvpu_pkg::PRIO_B] ? !v34 : a.req[2])
			? 3'h2 : w34;
		v67 = |a.req[7:6];
		w67 = (a.prio[lvpu_pkg::PRIO_C67] ? a.req[7] : !a.req[6])
			? 3'h7 : 3'h6;
		vc  = a.req[5] | v67;
		wc  = (a.prio[lvpu_pkg::PRIO_C] ? !v67 : a.req[5])
			? 3'h5 : w67;
	end

	// Group order comes from the register, never the level number [R02]
	always_comb begin
		a.found = va | vb | vc;
		case (a.prio[lvpu_pkg::PRIO_GRP +: 3]) // [R03]
			lvpu_pkg::G_ACB: a.level = va ? wa : (vc ? wc : wb);
			lvpu_pkg::G_BAC: a.level = vb ? wb : (va ? wa : wc);
			lvpu_pkg::G_BCA: a.level = vb ? wb : (vc ? wc : wa);
			lvpu_pkg::G_CAB: a.level = vc ? wc : (va ? wa : wb);
			lvpu_pkg::G_CBA: a.level = vc ? wc : (vb ? wb : wa);
			default:         a.level = va ? wa : (vb ? wb : wc);
		endcase
	end
endmodule
`default_nettype wire

// *** dv/lvpu_core_model.sv ***
// Processor core and program memory model facing the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module lvpu_core_model (
	// Clock and mode
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_slow,
	// Unit side
	input  wire logic        i_int_req,
	input  wire logic        i_rom_rd,
	input  wire logic [15:0] i_rom_addr,
	output logic             o_int_ack,
	output logic      [7:0]  o_rom_data
);
	logic [1:0] wait_cnt;
	// Slow mode holds the acknowledge off for three cycles of request
	always_ff @(posedge i_core_clk) begin
		if (i_rst || !i_int_req || o_int_ack) begin
			wait_cnt <= 2'h0;
		end else begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
	assign o_int_ack = i_int_req && (!i_slow || wait_cnt == 2'h3);
	// Between reads the bus toggles so stale data never looks valid
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rom_data <= 8'h00;
		end else if (i_rom_rd) begin
			o_rom_data <= i_rom_addr[7:0] ^ 8'h3C;
		end else begin
			o_rom_data <= ~o_rom_data;
		end
	end
endmodule
`default_nettype wire

// *** dv/lvpu_top_test.sv ***
// Self-checking bench of the leveled vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module lvpu_top_test;
	logic        i_core_clk = 1'b0;
	logic        i_rst      = 1'b1;
	logic [3:0]  addr       = 4'h0;
	logic [7:0]  wdata      = 8'h00;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic [10:0] evt        = 11'h000;
	logic [11:0] pin        = 12'h000;
	logic        g_on       = 1'b0;
	logic        g_off      = 1'b0;
	logic        slow       = 1'b0;
	logic        ack;
	logic        req;
	logic        rom_rd;
	logic [15:0] rom_addr;
	logic [7:0]  rom_data;
	logic [7:0]  rdata;
	logic [7:0]  vec;
	logic        push;
	logic        isr_v;
	logic [15:0] isr_a;
	logic        irq;
	logic        rd_seen = 1'b0;
	logic [3:0]  push_h  = 4'h0;
	logic [31:0] lfsr    = 32'h95C5;
	logic [7:0]  rq[$];
	logic [24:0] gq[$];
	logic [7:0]  exp_r;
	logic [24:0] exp_g;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc       = 0;
	logic [23:0] tbl[7] = '{24'hFF00E0, 24'hFFC5C8, 24'hFF33D6,
		24'hFF04D8, 24'hFE00E4, 24'hFC41C0, 24'hFF1AD0};

	always #10 i_core_clk = ~i_core_clk;

	lvpu_top u_lvpu_top (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_ce(1'b1), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_src_evt(evt), .i_ext_pin(pin), .i_glb_on(g_on),
		.i_glb_off(g_off), .i_int_ack(ack), .o_int_req(req),
		.o_vector(vec), .o_stack_push(push), .o_rom_rd(rom_rd),
		.o_rom_addr(rom_addr), .i_rom_data(rom_data),
		.o_isr_valid(isr_v), .o_isr_addr(isr_a), .o_irq(irq));

	lvpu_core_model u_lvpu_core_model (.i_core_clk(i_core_clk),
		.i_rst(i_rst), .i_slow(slow), .i_int_req(req),
		.i_rom_rd(rom_rd), .i_rom_addr(rom_addr), .o_int_ack(ack),
		.o_rom_data(rom_data));

	task automatic check(string nm, logic [24:0] seen, logic [24:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] lfsr_next(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic end_sim;
		// A noted result that never appeared is a missed answer
		if (rq.size() != 0 || gq.size() != 0) begin
			error_cnt++;
		end
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Results are compared in arrival order against the noted ones
	always @(posedge i_core_clk) begin
		cyc++;
		if (rd_seen) begin
			exp_r = rq.pop_front();
			check("rdata", {17'h0, rdata}, {17'h0, exp_r});
		end
		if (isr_v === 1'b1) begin
			exp_g = gq.pop_front();
			check("grant", {vec, isr_a, push_h[3]}, exp_g);
		end
		rd_seen <= rd;
		push_h <= {push_h[2:0], push};
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic wreg(logic [3:0] a, logic [7:0] d);
		@(posedge i_core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_core_clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(logic [3:0] a, logic [7:0] exp);
		@(posedge i_core_clk);
		rd <= 1'b1;
		addr <= a;
		rq.push_back(exp);
		@(posedge i_core_clk);
		rd <= 1'b0;
	endtask

	// Expected grant: vector, both scrambled memory bytes, push seen
	task automatic grant(logic [7:0] v);
		gq.push_back({v, v ^ 8'h3C, (v + 8'h01) ^ 8'h3C, 1'b1});
		@(posedge i_core_clk);
		g_on <= 1'b1;
		@(posedge i_core_clk);
		g_on <= 1'b0;
		for (int i = 0; i < 60; i++) begin
			@(posedge i_core_clk);
			if (isr_v === 1'b1) break;
		end
		repeat (2) @(posedge i_core_clk);
	endtask

	task automatic pulse(logic [10:0] e);
		@(posedge i_core_clk);
		evt <= e;
		@(posedge i_core_clk);
		evt <= 11'h000;
		repeat (2) @(posedge i_core_clk);
	endtask

	task automatic clr_all;
		wreg(lvpu_pkg::A_PEND0, 8'hFF);
		wreg(lvpu_pkg::A_PEND1, 8'hFF);
		wreg(lvpu_pkg::A_PEND2, 8'hFF);
	endtask

	initial begin
		logic [2:0] sub;
		logic [7:0] ev;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (int a = 0; a < 16; a++) rreg(4'(a), 8'h00);
		$display("test reset values done");
		@(posedge i_core_clk);
		g_on <= 1'b1;
		g_off <= 1'b1;
		@(posedge i_core_clk);
		g_on <= 1'b0;
		g_off <= 1'b0;
		rreg(lvpu_pkg::A_SYS, 8'h00);
		wreg(lvpu_pkg::A_SYS, 8'h01);
		rreg(lvpu_pkg::A_SYS, 8'h01);
		@(posedge i_core_clk);
		g_off <= 1'b1;
		@(posedge i_core_clk);
		g_off <= 1'b0;
		rreg(lvpu_pkg::A_SYS, 8'h00);
		$display("test global enable done");
		wreg(lvpu_pkg::A_MASK, 8'hFF);
		pulse(11'h003);
		grant(lvpu_pkg::VEC_E0);
		rreg(lvpu_pkg::A_SYS, 8'h00);
		wreg(lvpu_pkg::A_PEND0, 8'h01);
		rreg(lvpu_pkg::A_LREQ, 8'h01);
		grant(8'hE2);
		rreg(lvpu_pkg::A_PEND0, 8'h00);
		rreg(lvpu_pkg::A_LREQ, 8'h00);
		$display("test fixed order done");
		// Mask, priority, expected vector; pins fire on falling edge
		// The level request register is not masked: all levels show
		foreach (tbl[i]) begin
			wreg(lvpu_pkg::A_MASK, tbl[i][23:16]);
			wreg(lvpu_pkg::A_PRIO, tbl[i][15:8]);
			@(posedge i_core_clk);
			pin <= 12'h111;
			pulse(11'h495);
			repeat (3) @(posedge i_core_clk);
			pin <= 12'h000;
			repeat (6) @(posedge i_core_clk);
			rreg(lvpu_pkg::A_LREQ, 8'hFF);
			grant(tbl[i][7:0]);
			clr_all();
		end
		$display("test level priority done");
		wreg(lvpu_pkg::A_MASK, 8'hFF);
		slow <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			sub = (lfsr[2:0] == 3'h0) ? 3'h4 : lfsr[2:0];
			ev = sub[0] ? 8'hD0 : (sub[1] ? 8'hD2 : 8'hD4);
			pulse({1'b0, sub, 7'h00});
			grant(ev);
			clr_all();
		end
		slow <= 1'b0;
		$display("test random contention done");
		wreg(lvpu_pkg::A_EDGE1, 8'hFF);
		rreg(lvpu_pkg::A_EDGE1, 8'h0F);
		wreg(lvpu_pkg::A_EDGE0, 8'h01);
		@(posedge i_core_clk);
		pin <= 12'h003;
		repeat (6) @(posedge i_core_clk);
		rreg(lvpu_pkg::A_PEND1, 8'h08);
		@(posedge i_core_clk);
		pin <= 12'h000;
		repeat (6) @(posedge i_core_clk);
		rreg(lvpu_pkg::A_PEND1, 8'h18);
		clr_all();
		$display("test pin edges done");
		wreg(lvpu_pkg::A_SCLR, 8'hFF);
		wreg(lvpu_pkg::A_SEN, 8'h02);
		@(posedge i_core_clk);
		check("irq", {24'h0, irq}, 25'h0);
		pulse(11'h004);
		check("irq", {24'h0, irq}, 25'h1);
		rreg(lvpu_pkg::A_STAT, 8'h02);
		wreg(lvpu_pkg::A_SEN, 8'h00);
		@(posedge i_core_clk);
		check("irq", {24'h0, irq}, 25'h0);
		wreg(lvpu_pkg::A_SEN, 8'h02);
		clr_all();
		wreg(lvpu_pkg::A_SCLR, 8'h02);
		@(posedge i_core_clk);
		check("irq", {24'h0, irq}, 25'h0);
		rreg(lvpu_pkg::A_STAT, 8'h00);
		$display("test status interrupt done");
		repeat (4) @(posedge i_core_clk);
		end_sim();
	end
endmodule
`default_nettype wire
